// ==== design/sdmr_map.svh ====
// Register offsets, field positions and reset values of the mode register bank
`ifndef SDMR_MAP_SVH
`define SDMR_MAP_SVH
// Register addresses on the mode register command bus
`define SDMR_ADDR_LATENCY   8'h02
`define SDMR_ADDR_DRIVE     8'h03
`define SDMR_ADDR_TEMP      8'h04
`define SDMR_ADDR_MAKER     8'h05
`define SDMR_ADDR_REV_LO    8'h06
`define SDMR_ADDR_REV_HI    8'h07
`define SDMR_ADDR_GEOMETRY  8'h08
`define SDMR_ADDR_TEST      8'h09
// Field positions
`define SDMR_CODE_MSB       3
`define SDMR_FLAG_BIT       7
`define SDMR_RATE_MSB       2
`define SDMR_HOT_BIT        2
// Burst length codes
`define SDMR_BEATS_4        3'h2
`define SDMR_BEATS_8        3'h3
`define SDMR_BEATS_16       3'h4
// Refresh rate codes for limit violations and reset
`define SDMR_RATE_LOW       3'h0
`define SDMR_RATE_HIGH      3'h7
`define SDMR_RATE_1X        3'h3
// Reset values
`define SDMR_RST_LAT_CODE   4'h2
`define SDMR_RST_RD_LAT     4'h3
`define SDMR_RST_WR_LAT     4'h1
`define SDMR_RST_DRIVE      4'h2
// Geometry fields
`define SDMR_TYPE_PREFETCH4 2'h0
`define SDMR_DENS_1G        4'h4
`define SDMR_WIDTH_X32      2'h0
`define SDMR_WIDTH_X16      2'h1
`endif

// ==== design/sdmr_mode_regs.sv ====
// Mode register bank with temperature crossing and burst address forming
`timescale 1ns/1ns
`include "sdmr_map.svh"
// Functional notes
// - Lowest column bit always forced to zero
// - Burst address width follows burst length
// - Latency codes 2-4 give read latency 3-5
// - Drive strength codes decoded, others reserved
// - Refresh rate code reported in bits 2:0
// - Limit violations report codes 000 and 111
// - Rate bit two set above 85 C unless the low limit forces code 000
// - Update flag set on any rate change
// - Reading temperature register clears update flag
// - Update flag zero after power-up
// - Fixed maker identity byte at 05h
// - Fixed revision bytes at 06h and 07h
// - Geometry byte: type, density, width
// - Test register 09h reserved, no function
module sdmr_mode_regs #(
  parameter bit                  IS_X16  = 1'b1,   // Bus width strap: 1 for x16
  parameter int                  COL_W   = 10,     // Column address width
  parameter sdmr_pkg::sdmr_byte_t MAKER_ID = 8'h5a, // Value is arbitrary
  parameter sdmr_pkg::sdmr_byte_t REV_LO   = 8'h3c, // Value is arbitrary
  parameter sdmr_pkg::sdmr_byte_t REV_HI   = 8'hc3  // Value is arbitrary
) (
  // Core clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Temperature sensor, core domain
  input  wire sdmr_pkg::sdmr_rate_t temp_rate_raw,
  input  wire logic                 temp_low_limit,
  input  wire logic                 temp_high_limit,
  input  wire logic                 temp_above_85,
  // Mode register commands, link domain
  input  wire logic                 link_clk,
  input  wire logic                 mrw_strobe,
  input  wire logic                 mrr_strobe,
  input  wire sdmr_pkg::sdmr_byte_t mr_addr,
  input  wire sdmr_pkg::sdmr_byte_t mrw_data,
  output logic                      mrr_valid,
  output sdmr_pkg::sdmr_byte_t      mrr_data,
  // Burst column forming, link domain
  input  wire logic                 col_valid,
  input  wire logic [COL_W-1:0]     col_addr,
  input  wire logic [2:0]           burst_beats,
  output logic [3:0]                burst_offset,
  // Decoded settings, link domain
  output sdmr_pkg::sdmr_nib_t       read_latency,
  output sdmr_pkg::sdmr_nib_t       write_latency,
  output sdmr_pkg::sdmr_nib_t       drive_strength_sel,
  output logic                      temp_update_flag
);

  // Latency lookup: {valid, read, write}; codes outside 2..7 are reserved
  function automatic logic [8:0] lat_lookup(input sdmr_pkg::sdmr_nib_t code);
    unique case (code)
      4'h2:    lat_lookup = {1'b1, 4'h3, 4'h1};
      4'h3:    lat_lookup = {1'b1, 4'h4, 4'h2};
      4'h4:    lat_lookup = {1'b1, 4'h5, 4'h2};
      4'h5:    lat_lookup = {1'b1, 4'h6, 4'h3};
      4'h6:    lat_lookup = {1'b1, 4'h7, 4'h4};
      4'h7:    lat_lookup = {1'b1, 4'h8, 4'h4};
      default: lat_lookup = 9'h000;
    endcase
  endfunction : lat_lookup

  // ---------------- Core domain: sensor code and handshake ----------------
  logic                 req_q;       // Toggles for each new code sent
  sdmr_pkg::sdmr_rate_t xfer_q;      // Code held stable while in flight
  logic                 ack_s1_q;    // Ack synchroniser, first stage
  logic                 ack_s2_q;    // Ack synchroniser, second stage
  sdmr_pkg::sdmr_rate_t rate_code_w; // Code composed from the sensor
  logic                 xfer_busy_w; // Handshake still open
  logic                 xfer_load_w; // Launch a new code

  // Limits override the measured rate; heat forces bit two
  assign rate_code_w = temp_low_limit  ? `SDMR_RATE_LOW :
                       temp_high_limit ? `SDMR_RATE_HIGH :
                       (temp_rate_raw | {temp_above_85, 2'b00});
  assign xfer_busy_w = req_q ^ ack_s2_q;
  assign xfer_load_w = !xfer_busy_w && (rate_code_w != xfer_q);

  // Launch side of the word handshake; the code may not move while busy
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      req_q  <= 1'b0;
      xfer_q <= `SDMR_RATE_1X;
    end else if (xfer_load_w) begin
      req_q  <= ~req_q;
      xfer_q <= rate_code_w;
    end
  end

  logic req_s3_q; // Link side ack source, declared ahead for the ack sync

  // Bring the link acknowledge back into the core domain
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= req_s3_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // ---------------- Link domain ----------------
  logic                 lrst_s1_q;  // Reset synchroniser, first stage
  logic                 link_rst_n; // Reset as seen by the link domain
  logic                 req_s1_q;   // Request synchroniser, first stage
  logic                 req_s2_q;   // Request synchroniser, second stage
  sdmr_pkg::sdmr_rate_t rate_q;     // Refresh rate code as reported
  logic                 upd_flag_q; // Update flag
  logic                 capture_w;  // A new code has arrived
  logic                 changed_w;  // Arrived code differs from reported
  logic                 rd_temp_w;  // Read of the temperature register
  logic                 wr_lat_w;   // Write of the latency register
  logic                 wr_drv_w;   // Write of the drive register
  logic [8:0]           lat_w;      // Looked up latency pair
  logic                 drv_ok_w;   // Drive code is a legal one
  logic [3:0]           bmask_w;    // Burst address bits in use
  sdmr_pkg::sdmr_byte_t rd_mux_w;   // Read data selected by address

  // Reset passes two flops so it releases cleanly on the link clock
  always_ff @(posedge link_clk) begin
    lrst_s1_q  <= rst_b;
    link_rst_n <= lrst_s1_q;
  end

  // Request synchroniser plus a third stage for edge detection
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // Command decode
  assign capture_w = req_s2_q ^ req_s3_q;
  assign changed_w = capture_w && (xfer_q != rate_q);
  assign rd_temp_w = mrr_strobe && (mr_addr == `SDMR_ADDR_TEMP);
  assign wr_lat_w  = mrw_strobe && (mr_addr == `SDMR_ADDR_LATENCY);
  assign wr_drv_w  = mrw_strobe && (mr_addr == `SDMR_ADDR_DRIVE);
  assign lat_w     = lat_lookup(mrw_data[`SDMR_CODE_MSB:0]);
  // Legal drive codes are 1..4, 6 and 7
  assign drv_ok_w  = (mrw_data[7:3] == 5'h00) && (mrw_data[2:0] != 3'h0) &&
                     (mrw_data[2:0] != 3'h5);

  // Reported rate code; xfer_q is stable while the handshake is open
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      rate_q <= `SDMR_RATE_1X;
    end else if (capture_w) begin
      rate_q <= xfer_q;
    end
  end

  // Update flag: a change in the same cycle as a read wins over the clear
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      upd_flag_q <= 1'b0;
    end else if (changed_w) begin
      upd_flag_q <= 1'b1;
    end else if (rd_temp_w) begin
      upd_flag_q <= 1'b0;
    end
  end
  assign temp_update_flag = upd_flag_q;

  // Write-only latency register; a reserved code leaves the setting alone
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      read_latency  <= `SDMR_RST_RD_LAT;
      write_latency <= `SDMR_RST_WR_LAT;
    end else if (wr_lat_w && lat_w[8]) begin
      read_latency  <= lat_w[7:4];
      write_latency <= lat_w[3:0];
    end
  end

  // Write-only drive register, defaults to 40 ohm
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      drive_strength_sel <= `SDMR_RST_DRIVE;
    end else if (wr_drv_w && drv_ok_w) begin
      drive_strength_sel <= mrw_data[`SDMR_CODE_MSB:0];
    end
  end

  // Read mux; write-only, test and unmapped addresses read as zero
  always_comb begin
    unique case (mr_addr)
      `SDMR_ADDR_TEMP:     rd_mux_w = {upd_flag_q, 4'h0, rate_q};
      `SDMR_ADDR_MAKER:    rd_mux_w = MAKER_ID;
      `SDMR_ADDR_REV_LO:   rd_mux_w = REV_LO;
      `SDMR_ADDR_REV_HI:   rd_mux_w = REV_HI;
      `SDMR_ADDR_GEOMETRY: rd_mux_w = {(IS_X16 ? `SDMR_WIDTH_X16 : `SDMR_WIDTH_X32),
                                       `SDMR_DENS_1G, `SDMR_TYPE_PREFETCH4};
      `SDMR_ADDR_TEST:     rd_mux_w = 8'h00;
      default:             rd_mux_w = 8'h00;
    endcase
  end

  // Read answer one link cycle after the command
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      mrr_valid <= 1'b0;
      mrr_data  <= 8'h00;
    end else begin
      mrr_valid <= mrr_strobe;
      mrr_data  <= mrr_strobe ? rd_mux_w : 8'h00;
    end
  end

  // Burst address bits; column bit zero may arrive set and is masked to zero below
  assign bmask_w = (burst_beats == `SDMR_BEATS_16) ? 4'hf :
                   (burst_beats == `SDMR_BEATS_8)  ? 4'h7 :
                   (burst_beats == `SDMR_BEATS_4)  ? 4'h3 : 4'h0;
  // Start offset inside the burst; the host keeps no-wrap starts legal
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      burst_offset <= 4'h0;
    end else if (col_valid) begin
      burst_offset <= col_addr[3:0] & bmask_w & 4'he;
    end
  end

  // ---------------- Checks ----------------
  sequence s_read(logic [7:0] a);
    mrr_strobe && (mr_addr == a);
  endsequence

  property p_col_zero;
    @(posedge link_clk) disable iff (!link_rst_n)
      col_valid |=> !burst_offset[0];
  endproperty
  a_col_zero: assert property (p_col_zero) else $error("Column bit zero not zero");

  property p_burst_width;
    @(posedge link_clk) disable iff (!link_rst_n)
      col_valid && (burst_beats == `SDMR_BEATS_4) |=> (burst_offset[3:2] == 2'b00);
  endproperty
  a_burst_width: assert property (p_burst_width) else $error("Four-beat offset too wide");

  property p_lat_rl3;
    @(posedge link_clk) disable iff (!link_rst_n)
      wr_lat_w && (mrw_data[3:0] == 4'h2) |=> (read_latency == 4'h3)
        && (write_latency == 4'h1);
  endproperty
  a_lat_rl3: assert property (p_lat_rl3) else $error("Latency code 2 wrong");

  property p_lat_rsvd;
    @(posedge link_clk) disable iff (!link_rst_n)
      wr_lat_w && (mrw_data[3:0] > 4'h7) |=> $stable(read_latency);
  endproperty
  a_lat_rsvd: assert property (p_lat_rsvd) else $error("Reserved latency taken");

  property p_drive;
    @(posedge link_clk) disable iff (!link_rst_n)
      wr_drv_w && (mrw_data == 8'h05) |=> $stable(drive_strength_sel);
  endproperty
  a_drive: assert property (p_drive) else $error("Reserved drive code taken");

  property p_temp_read;
    @(posedge link_clk) disable iff (!link_rst_n)
      s_read(`SDMR_ADDR_TEMP) |=> mrr_valid && (mrr_data[2:0] == $past(rate_q))
        && (mrr_data[7] == $past(upd_flag_q));
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("Temperature read wrong");

  property p_flag_set;
    @(posedge link_clk) disable iff (!link_rst_n)
      changed_w |=> upd_flag_q && (rate_q != $past(rate_q));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Update flag not set");

  property p_flag_clear;
    @(posedge link_clk) disable iff (!link_rst_n)
      s_read(`SDMR_ADDR_TEMP) ##0 !changed_w |=> !upd_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Update flag not cleared");

  property p_flag_reset;
    @(posedge link_clk) $rose(link_rst_n) |-> !upd_flag_q;
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("Update flag set after reset");

  property p_hot;
    @(posedge clock) disable iff (!rst_b)
      xfer_load_w && temp_above_85 && !temp_low_limit |=> xfer_q[`SDMR_HOT_BIT];
  endproperty
  a_hot: assert property (p_hot) else $error("Hot bit not sent");

  property p_maker;
    @(posedge link_clk) disable iff (!link_rst_n)
      s_read(`SDMR_ADDR_MAKER) |=> mrr_valid && (mrr_data == MAKER_ID);
  endproperty
  a_maker: assert property (p_maker) else $error("Maker byte wrong");

  property p_geometry;
    @(posedge link_clk) disable iff (!link_rst_n)
      s_read(`SDMR_ADDR_GEOMETRY) |=> (mrr_data[5:0] == 6'h10)
        && (mrr_data[7:6] == {1'b0, IS_X16});
  endproperty
  a_geometry: assert property (p_geometry) else $error("Geometry byte wrong");

endmodule : sdmr_mode_regs

// ==== design/sdmr_pkg.sv ====
// Types shared by the mode register bank
package sdmr_pkg;
  typedef logic [7:0] sdmr_byte_t;   // One mode register byte
  typedef logic [3:0] sdmr_nib_t;    // Latency or drive code
  typedef logic [2:0] sdmr_rate_t;   // Refresh rate code
endpackage : sdmr_pkg

// ==== verif/sdmr_host_model.sv ====
// Host controller model issuing mode register commands and bursts
`timescale 1ns/1ns
module sdmr_host_model (
  // Link clock and read answer
  input  wire logic                 link_clk,
  input  wire logic                 mrr_valid,
  input  wire sdmr_pkg::sdmr_byte_t mrr_data,
  // Mode register commands
  output logic                      mrw_strobe,
  output logic                      mrr_strobe,
  output sdmr_pkg::sdmr_byte_t      mr_addr,
  output sdmr_pkg::sdmr_byte_t      mrw_data,
  // Burst start column
  output logic                      col_valid,
  output logic [9:0]                col_addr,
  output logic [2:0]                burst_beats
);
  logic derate;  // Set by a temperature read that returns rate code 6
  // Idle bus at time zero
  initial begin
    mrw_strobe  = 1'b0;
    mrr_strobe  = 1'b0;
    col_valid   = 1'b0;
    mr_addr     = 8'h00;
    mrw_data    = 8'h00;
    col_addr    = 10'h000;
    burst_beats = 3'h0;
    derate      = 1'b0;
  end
  // Write; released lines show the inverse so stale values never match
  task automatic mrw(input sdmr_pkg::sdmr_byte_t a, input sdmr_pkg::sdmr_byte_t d);
    @(posedge link_clk);
    mrw_strobe <= 1'b1;
    mr_addr    <= a;
    mrw_data   <= d;
    @(posedge link_clk);
    mrw_strobe <= 1'b0;
    mr_addr    <= ~a;
    mrw_data   <= ~d;
    @(posedge link_clk);
  endtask : mrw
  // Read; answer sampled one edge after the taking edge
  task automatic mrr(input sdmr_pkg::sdmr_byte_t a, output logic v,
                     output sdmr_pkg::sdmr_byte_t d);
    @(posedge link_clk);
    mrr_strobe <= 1'b1;
    mr_addr    <= a;
    @(posedge link_clk);
    mrr_strobe <= 1'b0;
    mr_addr    <= ~a;
    @(posedge link_clk);
    v = mrr_valid;
    d = mrr_data;
    if (a == 8'h04) begin
      derate = (d[2:0] == 3'h6);
    end
  endtask : mrr
  // Burst start; no-wrap starts are made legal before driving
  task automatic burst(input logic no_wrap, inout logic [9:0] c, inout logic [2:0] b);
    if (no_wrap) begin
      b    = 3'h2;
      c[0] = 1'b0;
      if (c[8:1] == 8'hff || c[8:1] == 8'h00) begin
        c = c + 10'h004;
      end
    end
    @(posedge link_clk);
    col_valid   <= 1'b1;
    col_addr    <= c;
    burst_beats <= b;
    @(posedge link_clk);
    col_valid   <= 1'b0;
    col_addr    <= ~c;
    burst_beats <= ~b;
    @(posedge link_clk);
  endtask : burst
endmodule : sdmr_host_model

// ==== verif/sdram_mode_register_set_tb.sv ====
// Self-checking bench for the mode register bank
`timescale 1ns/1ns
module sdram_mode_register_set_tb;
  localparam logic [7:0] RA [8] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h2a};
  localparam logic [7:0] RE [8] = '{8'h00, 8'h00, 8'h69, 8'h4d, 8'hb2, 8'h50, 8'h00, 8'h00};
  localparam logic [2:0] RATES [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  logic                 clock, rst_b, link_clk;
  sdmr_pkg::sdmr_rate_t temp_rate_raw;
  logic                 temp_low_limit, temp_high_limit, temp_above_85;
  logic                 mrw_strobe, mrr_strobe, mrr_valid, col_valid, temp_update_flag;
  sdmr_pkg::sdmr_byte_t mr_addr, mrw_data, mrr_data;
  logic [9:0]           col_addr;
  logic [2:0]           burst_beats;
  logic [3:0]           burst_offset;
  sdmr_pkg::sdmr_nib_t  read_latency, write_latency, drive_strength_sel;
  int                   miscompares = 0;
  int                   check_count = 0;
  int                   seed = 40232;
  // Identity values below are arbitrary
  sdmr_mode_regs #(.IS_X16(1'b1), .COL_W(10), .MAKER_ID(8'h69), .REV_LO(8'h4d),
                   .REV_HI(8'hb2)) uut (
    .clock(clock), .rst_b(rst_b), .temp_rate_raw(temp_rate_raw),
    .temp_low_limit(temp_low_limit), .temp_high_limit(temp_high_limit),
    .temp_above_85(temp_above_85), .link_clk(link_clk), .mrw_strobe(mrw_strobe),
    .mrr_strobe(mrr_strobe), .mr_addr(mr_addr), .mrw_data(mrw_data),
    .mrr_valid(mrr_valid), .mrr_data(mrr_data), .col_valid(col_valid),
    .col_addr(col_addr), .burst_beats(burst_beats), .burst_offset(burst_offset),
    .read_latency(read_latency), .write_latency(write_latency),
    .drive_strength_sel(drive_strength_sel), .temp_update_flag(temp_update_flag));
  sdmr_host_model host (
    .link_clk(link_clk), .mrr_valid(mrr_valid), .mrr_data(mrr_data),
    .mrw_strobe(mrw_strobe), .mrr_strobe(mrr_strobe), .mr_addr(mr_addr),
    .mrw_data(mrw_data), .col_valid(col_valid), .col_addr(col_addr),
    .burst_beats(burst_beats));
  // Core clock 20 ns; link clock 6 ns with its own phase
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #3 link_clk = ~link_clk;
  end
  // Comparisons, one per kind of result
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk_byte
  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic       v;
    logic [7:0] d;
    host.mrr(a, v, d);
    chk_bit("mrr_valid", 1'b1, v);
    chk_byte("mrr_data", exp, d);
  endtask : rd_chk
  // Expected values
  function automatic logic [7:0] lat_exp(input logic [3:0] c, input logic [7:0] old);
    case (c)
      4'h2: return 8'h31;
      4'h3: return 8'h42;
      4'h4: return 8'h52;
      4'h5: return 8'h63;
      4'h6: return 8'h74;
      4'h7: return 8'h84;
      default: return old;
    endcase
  endfunction : lat_exp
  function automatic logic [3:0] drv_exp(input logic [3:0] c, input logic [3:0] old);
    return (c inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7}) ? c : old;
  endfunction : drv_exp
  function automatic logic [2:0] rate_exp(input logic lo, hi, h, input logic [2:0] raw);
    return lo ? 3'h0 : hi ? 3'h7 : (raw | {h, 2'b00});
  endfunction : rate_exp
  function automatic logic [3:0] off_exp(input logic [9:0] c, input logic [2:0] b);
    logic [3:0] m;
    m = (b == 3'h2) ? 4'h3 : (b == 3'h3) ? 4'h7 : (b == 3'h4) ? 4'hf : 4'h0;
    return c[3:0] & m & 4'he;
  endfunction : off_exp
  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Hang guard
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    end_of_test;
  end
  // Main sequence
  initial begin
    logic [7:0] lw;
    logic [3:0] dv;
    logic [2:0] e, pe, b;
    logic [9:0] c;
    logic       seen;
    logic       lo, hi;
    int         i, k;
    rst_b           = 1'b0;
    temp_rate_raw   = 3'h3;
    temp_low_limit  = 1'b0;
    temp_high_limit = 1'b0;
    temp_above_85   = 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    chk_byte("latency", 8'h31, {read_latency, write_latency});
    chk_byte("drive", 8'h02, {4'h0, drive_strength_sel});
    chk_bit("temp_update_flag", 1'b0, temp_update_flag);
    rd_chk(8'h04, 8'h03);
    // Every latency and drive code, reserved ones keep the old value
    lw = 8'h31;
    dv = 4'h2;
    for (k = 0; k < 16; k++) begin
      host.mrw(8'h02, {4'h0, k[3:0]});
      lw = lat_exp(k[3:0], lw);
      chk_byte("latency", lw, {read_latency, write_latency});
      host.mrw(8'h03, {4'h0, k[3:0]});
      dv = drv_exp(k[3:0], dv);
      chk_byte("drive", {4'h0, dv}, {4'h0, drive_strength_sel});
    end
    // Writes to read-only and reserved places must change nothing
    for (k = 4; k < 10; k++) begin
      host.mrw(k[7:0], 8'hff);
    end
    host.mrw(8'h03, 8'h71);
    chk_byte("drive", {4'h0, dv}, {4'h0, drive_strength_sel});
    foreach (RA[i]) begin
      rd_chk(RA[i], RE[i]);
    end
    // Sensor codes with limit corners; flag follows changes only
    pe = 3'h3;
    for (i = 0; i < 20; i++) begin
      k = $random(seed);
      // First pass both limits, second pass the high limit alone
      lo = ((k[3:1] == 3'h0) || (i == 0)) && (i != 1);
      hi = (k[3:1] == 3'h1) || (i < 2);
      @(posedge clock);
      temp_low_limit  <= lo;
      temp_high_limit <= hi;
      temp_above_85   <= k[4];
      temp_rate_raw   <= RATES[k[8:6] % 5];
      e = rate_exp(lo, hi, k[4], RATES[k[8:6] % 5]);
      seen = 1'b0;
      for (k = 0; k < 40 && !seen; k++) begin
        @(posedge link_clk);
        seen = (temp_update_flag === 1'b1);
      end
      chk_bit("temp_update_flag", e != pe, seen);
      rd_chk(8'h04, {e != pe, 4'h0, e});
      chk_bit("temp_update_flag", 1'b0, temp_update_flag);
      pe = e;
    end
    // Burst columns, first one odd at the top of the page
    for (i = 0; i < 24; i++) begin
      c = 10'($random(seed));
      b = 3'($random(seed));
      if (i == 0) begin
        c = 10'h3ff;
        b = 3'h4;
      end
      // Eight-beat corner so that length is surely seen
      if (i == 2) begin
        b = 3'h3;
      end
      host.burst(i % 4 == 1, c, b);
      chk_byte("burst_offset", {4'h0, off_exp(c, b)}, {4'h0, burst_offset});
    end
    end_of_test;
  end
endmodule : sdram_mode_register_set_tb
